// File: hw/mimc_params.svh
`ifndef MIMC_PARAMS_SVH
`define MIMC_PARAMS_SVH

`define MIMC_ADDR_W         8
`define MIMC_DATA_W         16
`define MIMC_CTRL_ADDR      8'h17
`define MIMC_IRQ_STS_ADDR   8'h20
`define MIMC_IRQ_MSK_ADDR   8'h21

`define MIMC_CTRL_RESET     16'h4041
`define MIMC_CTRL_WMASK     16'h7ff3

`define MIMC_BIT_RX_DLY     12
`define MIMC_BIT_TX_DLY     11
`define MIMC_BIT_RGMII      9
`define MIMC_BIT_RMII       5

`define MIMC_IRQ_OVF        0
`define MIMC_IRQ_UNF        1
`define MIMC_IRQ_RESET      2'h0

`define MIMC_RGMII_DELAY_NS 4'h2
`define MIMC_NO_DELAY_NS    4'h0

`define MIMC_STRAP_LOAD     3'h3
`define MIMC_STRAP_DONE     3'h4

`endif

// File: hw/mimc_pkg.sv
package mimc_pkg;

  typedef enum logic [2:0] {
    MIMC_MII   = 3'h1,
    MIMC_RMII  = 3'h2,
    MIMC_RGMII = 3'h4
  } mimc_mode_type;

  typedef enum logic [3:0] {
    EB_IDLE = 4'h1,
    EB_PRE  = 4'h2,
    EB_RUN  = 4'h4,
    EB_TAIL = 4'h8
  } mimc_state_type;

  typedef struct packed {
    logic       rsv15;
    logic [1:0] sgmii_thr;
    logic       rx_dly;
    logic       tx_dly;
    logic       rsv10;
    logic       rgmii;
    logic       rsv8;
    logic       clk_sel;
    logic       rsv6;
    logic       rmii;
    logic       rev10;
    logic       ovf_ok;
    logic       unf_ok;
    logic [1:0] ebuf_tol;
  } mimc_ctrl_type;

  typedef struct packed {
    logic       strap_rgmii;
    logic       strap_rmii;
    logic       strap_clk_sel;
    logic       strap_rx_dly;
    logic       strap_tx_dly;
    logic [1:0] rec_data;
    logic       rec_dv;
    logic       rec_clk;
    logic       ref_clk;
  } mimc_pin_type;

  typedef struct packed {
    logic       crs_dv;
    logic [1:0] rxd;
  } mimc_rmii_type;

endpackage

// File: hw/mimc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mimc_params.svh"

// Function
// [RULE_01] Bits 14:13 pick the SGMII half-full threshold 5, 2, 6 or 10 bits, reset to 10.
// [RULE_02] Bit 12 set delays the RGMII receive clock 2ns against data, clear keeps them aligned.
// [RULE_03] Bit 11 set delays the RGMII transmit clock 2ns against data, clear keeps them aligned.
// [RULE_04] Bit 9 set selects RGMII, clear lets the RMII/MII bit decide.
// [RULE_05] Without RGMII, bit 5 set selects RMII and clear selects MII.
// [RULE_06] Bit 7 tells the reference clock, 1 for 50MHz oscillator, 0 for 25MHz, default strapped.
// [RULE_07] Bit 4 picks RMII revision 1.0 when set and 1.2 when clear, reset to 0.
// [RULE_08] Revision 1.0 holds CRS_DV high until the last receive data has left.
// [RULE_09] Revision 1.2 toggles CRS_DV near the packet end to show carrier has dropped.
// [RULE_10] Bit 3 reads 1 when normal and 0 after a receive FIFO overflow, and a read clears it; the code resets it to 0, so the first read returns 0.
// [RULE_11] Bit 2 reads 1 when normal and 0 after a receive FIFO underflow, and a read clears it; the code resets it to 0, so the first read returns 0.
// [RULE_12] Bits 1:0 set the elasticity tolerance 5, 2, 3 or 4 bits per packet, reset to 01.
// [RULE_13] The elasticity buffer absorbs the rate gap between RMII clock and recovered data.
// [RULE_14] The smallest tolerance covers standard frames at 100ppm, larger frames need more.
// [RULE_15] The clock select default comes from a strap naming the clock the board supplies.
// [RULE_16] Strap values load the RGMII, RMII, clock select and both delay bits after reset.
// [RULE_17] Software keeps reserved bits at reset values, writing 1 to bit 6.
module mimc_top
  import mimc_pkg::*;
#(
  parameter int EB_DEPTH = 8
) (
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  input  wire logic [`MIMC_ADDR_W-1:0] reg_addr,
  input  wire logic [`MIMC_DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`MIMC_DATA_W-1:0] reg_rdata,
  input  wire logic                    strap_rgmii,
  input  wire logic                    strap_rmii,
  input  wire logic                    strap_clk_sel,
  input  wire logic                    strap_rx_dly,
  input  wire logic                    strap_tx_dly,
  input  wire logic                    ref_clk_pin,
  input  wire logic                    rec_clk_pin,
  input  wire logic                    rec_dv_pin,
  input  wire logic [1:0]              rec_data_pin,
  output mimc_mode_type                mode,
  output logic                         clk_sel_50m,
  output logic      [3:0]              rx_delay_ns,
  output logic      [3:0]              tx_delay_ns,
  output logic      [3:0]              sgmii_thr_bits,
  output logic      [3:0]              ebuf_tol_bits,
  output logic                         rmii_crs_dv,
  output logic      [1:0]              rmii_rxd,
  output logic                         irq
);

  localparam int AW = $clog2(EB_DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(EB_DEPTH);

  // Pin synchronisers, one level per bit
  logic [9:0]     pin_w;
  logic [9:0]     s1_q;
  logic [9:0]     s2_q;
  logic [9:0]     s3_q;
  logic [9:0]     lvl_q;
  logic [9:0]     lvl_d;
  mimc_pin_type   pin_now;
  mimc_pin_type   pin_old;
  logic           ref_rise;
  logic           rec_rise;

  assign pin_w = {strap_rgmii, strap_rmii, strap_clk_sel, strap_rx_dly, strap_tx_dly,
                  rec_data_pin, rec_dv_pin, rec_clk_pin, ref_clk_pin};

  always_comb begin
    // Level moves only when second and third stage agree
    lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q  <= 10'h000;
      s2_q  <= 10'h000;
      s3_q  <= 10'h000;
      lvl_q <= 10'h000;
    end else begin
      s1_q  <= pin_w;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign pin_now  = mimc_pin_type'(lvl_d);
  assign pin_old  = mimc_pin_type'(lvl_q);
  assign ref_rise = pin_now.ref_clk & ~pin_old.ref_clk;
  assign rec_rise = pin_now.rec_clk & ~pin_old.rec_clk;

  // Strap capture a few cycles after release, once synchronisers settled
  logic [2:0]     wait_q;
  logic [2:0]     wait_d;
  logic           strap_load;

  always_comb begin
    wait_d = wait_q;
    if (wait_q != `MIMC_STRAP_DONE) begin
      wait_d = wait_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 3'h0;
    end else begin
      wait_q <= wait_d;
    end
  end

  assign strap_load = (wait_q == `MIMC_STRAP_LOAD);

  // Control register
  mimc_ctrl_type  ctrl_q;
  mimc_ctrl_type  ctrl_d;
  logic           ovf_evt;
  logic           unf_evt;
  logic           ctrl_wr;
  logic           ctrl_rd;
  logic           sts_wr;
  logic           msk_wr;

  assign ctrl_wr = reg_wr && (reg_addr == `MIMC_CTRL_ADDR);
  assign ctrl_rd = reg_rd && (reg_addr == `MIMC_CTRL_ADDR);
  assign sts_wr  = reg_wr && (reg_addr == `MIMC_IRQ_STS_ADDR);
  assign msk_wr  = reg_wr && (reg_addr == `MIMC_IRQ_MSK_ADDR);

  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = mimc_ctrl_type'((reg_wdata & `MIMC_CTRL_WMASK) |
                               (ctrl_q & ~`MIMC_CTRL_WMASK));
    end
    if (ctrl_rd) begin
      ctrl_d.ovf_ok = 1'b1; // [RULE_10]
      ctrl_d.unf_ok = 1'b1; // [RULE_11]
    end
    // Detection wins over a clearing read in the same cycle
    if (ovf_evt) begin
      ctrl_d.ovf_ok = 1'b0; // [RULE_10]
    end
    if (unf_evt) begin
      ctrl_d.unf_ok = 1'b0; // [RULE_11]
    end
    // Agreed level; the registered copy is still at reset value here
    if (strap_load) begin
      ctrl_d.rgmii   = pin_now.strap_rgmii; // [RULE_16]
      ctrl_d.rmii    = pin_now.strap_rmii; // [RULE_16]
      ctrl_d.clk_sel = pin_now.strap_clk_sel; // [RULE_06] [RULE_15]
      ctrl_d.rx_dly  = pin_now.strap_rx_dly; // [RULE_16]
      ctrl_d.tx_dly  = pin_now.strap_tx_dly; // [RULE_16]
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= mimc_ctrl_type'(`MIMC_CTRL_RESET); // [RULE_01] [RULE_07] [RULE_12]
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Mode and decoded settings
  logic           rmii_en;

  always_comb begin
    if (ctrl_q.rgmii) begin
      mode = MIMC_RGMII; // [RULE_04]
    end else if (ctrl_q.rmii) begin
      mode = MIMC_RMII; // [RULE_05]
    end else begin
      mode = MIMC_MII; // [RULE_05]
    end
  end

  assign rmii_en     = (mode == MIMC_RMII);
  assign clk_sel_50m = ctrl_q.clk_sel; // [RULE_06]
  // Delay values go to the pad delay cells; no core logic can make 2ns
  assign rx_delay_ns = ctrl_q.rx_dly ? `MIMC_RGMII_DELAY_NS : `MIMC_NO_DELAY_NS; // [RULE_02]
  assign tx_delay_ns = ctrl_q.tx_dly ? `MIMC_RGMII_DELAY_NS : `MIMC_NO_DELAY_NS; // [RULE_03]

  always_comb begin
    unique case (ctrl_q.sgmii_thr) // [RULE_01]
      2'h0: sgmii_thr_bits = 4'h5;
      2'h1: sgmii_thr_bits = 4'h2;
      2'h2: sgmii_thr_bits = 4'h6;
      2'h3: sgmii_thr_bits = 4'ha;
    endcase
    unique case (ctrl_q.ebuf_tol) // [RULE_12] [RULE_14]
      2'h0: ebuf_tol_bits = 4'h5;
      2'h1: ebuf_tol_bits = 4'h2;
      2'h2: ebuf_tol_bits = 4'h3;
      2'h3: ebuf_tol_bits = 4'h4;
    endcase
  end

  // Receive elasticity buffer, filled at recovered rate, drained at RMII rate
  logic [1:0]     mem_q [EB_DEPTH];
  logic [AW-1:0]  wr_q;
  logic [AW-1:0]  wr_d;
  logic [AW-1:0]  rd_q;
  logic [AW-1:0]  rd_d;
  logic [AW:0]    cnt_q;
  logic [AW:0]    cnt_d;
  logic [AW:0]    prefill;
  mimc_state_type st_q;
  mimc_state_type st_d;
  mimc_rmii_type  out_q;
  mimc_rmii_type  out_d;
  logic           push;
  logic           pop;

  // Tolerance bits held back before data starts, in dibits rounded up
  assign prefill = (AW+1)'((ebuf_tol_bits + 4'h1) >> 1); // [RULE_12] [RULE_13]

  always_comb begin
    st_d    = st_q;
    out_d   = out_q;
    wr_d    = wr_q;
    rd_d    = rd_q;
    cnt_d   = cnt_q;
    push    = 1'b0;
    pop     = 1'b0;
    ovf_evt = 1'b0;
    unf_evt = 1'b0;
    if (!rmii_en) begin
      st_d  = EB_IDLE;
      out_d = 3'h0;
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (ref_rise) begin
        unique case (st_q)
          EB_IDLE: begin
            out_d = 3'h0;
            if (cnt_q != '0) begin
              st_d  = EB_PRE;
              out_d = {1'b1, 2'h0};
            end
          end
          EB_PRE: begin
            out_d = {1'b1, 2'h0};
            if (cnt_q >= prefill) begin
              st_d = EB_RUN; // [RULE_13]
            end
          end
          EB_RUN: begin
            out_d = {1'b1, 2'h0};
            if (cnt_q != '0) begin
              pop   = 1'b1;
              out_d = {1'b1, mem_q[rd_q]};
            end else if (pin_now.rec_dv) begin
              unf_evt = 1'b1; // [RULE_11]
            end
            if (!pin_now.rec_dv) begin
              st_d = EB_TAIL;
            end
          end
          EB_TAIL: begin
            if (cnt_q != '0) begin
              pop   = 1'b1;
              // Rev 1.0 holds, rev 1.2 toggles while the tail drains
              out_d = {ctrl_q.rev10 | ~out_q.crs_dv, mem_q[rd_q]}; // [RULE_08] [RULE_09]
            end else begin
              st_d  = EB_IDLE;
              out_d = 3'h0;
            end
          end
          default: begin
            st_d  = EB_IDLE;
            out_d = 3'h0;
          end
        endcase
      end
      if (rec_rise && pin_now.rec_dv) begin
        if ((cnt_q != FULL) || pop) begin
          push = 1'b1;
        end else begin
          ovf_evt = 1'b1; // [RULE_10]
        end
      end
      if (push) begin
        wr_d = wr_q + AW'(1);
      end
      if (pop) begin
        rd_d = rd_q + AW'(1);
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q  <= EB_IDLE;
      out_q <= 3'h0;
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      out_q <= out_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; nothing reads an entry before it is written
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= pin_now.rec_data;
    end
  end

  assign rmii_crs_dv = out_q.crs_dv;
  assign rmii_rxd    = out_q.rxd;

  // Interrupt status and mask
  logic [1:0]     sts_q;
  logic [1:0]     sts_d;
  logic [1:0]     msk_q;
  logic [1:0]     msk_d;

  always_comb begin
    sts_d = sts_q;
    msk_d = msk_q;
    if (sts_wr) begin
      sts_d = sts_q & ~reg_wdata[1:0];
    end
    sts_d[`MIMC_IRQ_OVF] = sts_d[`MIMC_IRQ_OVF] | ovf_evt;
    sts_d[`MIMC_IRQ_UNF] = sts_d[`MIMC_IRQ_UNF] | unf_evt;
    if (msk_wr) begin
      msk_d = reg_wdata[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sts_q <= `MIMC_IRQ_RESET;
      msk_q <= `MIMC_IRQ_RESET;
    end else begin
      sts_q <= sts_d;
      msk_q <= msk_d;
    end
  end

  assign irq = |(sts_q & msk_q);

  // Read port, data valid for one cycle only
  logic [`MIMC_DATA_W-1:0] rdata_q;
  logic [`MIMC_DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `MIMC_CTRL_ADDR:    rdata_d = ctrl_q;
        `MIMC_IRQ_STS_ADDR: rdata_d = {14'h0000, sts_q};
        `MIMC_IRQ_MSK_ADDR: rdata_d = {14'h0000, msk_q};
        default:            rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_ctrl_wr;
    ctrl_wr && !strap_load;
  endsequence

  sequence s_tail_step;
    (st_q == EB_TAIL) && ref_rise && rmii_en && (cnt_q != '0);
  endsequence

  a_thr_write: assert property ( // [RULE_01]
    s_ctrl_wr ##0 (reg_wdata[14:13] == 2'h3) |=> (sgmii_thr_bits == 4'ha))
    else $error("threshold code 11 not giving 10 bits");

  a_rx_delay_on: assert property ( // [RULE_02]
    s_ctrl_wr ##0 reg_wdata[`MIMC_BIT_RX_DLY] |=> (rx_delay_ns == `MIMC_RGMII_DELAY_NS))
    else $error("receive delay not applied");

  a_tx_delay_off: assert property ( // [RULE_03]
    s_ctrl_wr ##0 !reg_wdata[`MIMC_BIT_TX_DLY] |=> (tx_delay_ns == `MIMC_NO_DELAY_NS))
    else $error("transmit delay not removed");

  a_rgmii_select: assert property ( // [RULE_04]
    s_ctrl_wr ##0 reg_wdata[`MIMC_BIT_RGMII] |=> (mode == MIMC_RGMII))
    else $error("rgmii mode not selected");

  a_rmii_select: assert property ( // [RULE_05]
    s_ctrl_wr ##0 (!reg_wdata[`MIMC_BIT_RGMII] && reg_wdata[`MIMC_BIT_RMII])
    |=> (mode == MIMC_RMII) ##1 (cnt_q == '0 || rmii_en))
    else $error("rmii mode not selected");

  a_strap_capture: assert property ( // [RULE_15]
    strap_load |=> (clk_sel_50m == $past(pin_now.strap_clk_sel)) &&
                   (ctrl_q.rgmii == $past(pin_now.strap_rgmii)))
    else $error("strap values not loaded");

  a_rev10_hold: assert property ( // [RULE_08]
    s_tail_step ##0 ctrl_q.rev10 |=> rmii_crs_dv)
    else $error("crs_dv dropped in revision 1.0 tail");

  a_rev12_toggle: assert property ( // [RULE_09]
    s_tail_step ##0 !ctrl_q.rev10 |=> (rmii_crs_dv != $past(rmii_crs_dv)))
    else $error("crs_dv not toggling in revision 1.2 tail");

  a_ovf_detect: assert property ( // [RULE_10]
    ovf_evt |=> !ctrl_q.ovf_ok && sts_q[`MIMC_IRQ_OVF])
    else $error("overflow not flagged");

  a_ovf_clear: assert property ( // [RULE_10]
    ctrl_rd && !ovf_evt |=> ctrl_q.ovf_ok)
    else $error("overflow flag not cleared by read");

  a_unf_detect: assert property ( // [RULE_11]
    unf_evt |=> !ctrl_q.unf_ok && sts_q[`MIMC_IRQ_UNF])
    else $error("underflow not flagged");

  a_prefill_gate: assert property ( // [RULE_13]
    (st_q == EB_PRE) && (st_d == EB_RUN) |-> (cnt_q >= prefill))
    else $error("data released before prefill");

  a_rdata_once: assert property (
    !$past(reg_rd) |-> (reg_rdata == 16'h0000))
    else $error("read data outside its cycle");

endmodule

`default_nettype wire

// File: tb/mimc_mac_model.sv
`timescale 1ns/1ps
`default_nettype none

// Receiving side of the link, the controller that listens to the block.
module mimc_mac_model (
  output logic            ref_clk,
  input  wire logic       crs_dv,
  input  wire logic [1:0] rxd
);
  logic [1:0] got [$];
  int         falls;
  int         frames;
  int         idle_run;
  logic       in_frame;
  logic       last_dv;

  // Board oscillator runs free, phase unrelated to the core clock
  initial begin
    ref_clk = 1'b0;
    #7.3;
    forever #40 ref_clk = ~ref_clk;
  end

  initial begin
    falls    = 0;
    frames   = 0;
    idle_run = 0;
    in_frame = 1'b0;
    last_dv  = 1'b0;
  end

  // Frame ends after two quiet reference edges, so a toggling tail stays inside
  always @(posedge ref_clk) begin
    if (in_frame) begin
      got.push_back(rxd);
      if (last_dv && !crs_dv) falls++;
      idle_run = crs_dv ? 0 : idle_run + 1;
      if (idle_run == 2) begin
        in_frame = 1'b0;
        frames++;
      end
    end else if (crs_dv === 1'b1) begin
      got.delete();
      got.push_back(rxd);
      in_frame = 1'b1;
      falls    = 0;
      idle_run = 0;
    end
    last_dv = crs_dv;
  end
endmodule

`default_nettype wire

// File: tb/mimc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mimc_params.svh"

module mimc_top_bench;
  import mimc_pkg::*;
  logic          core_clk;
  logic          arst_n;
  logic [7:0]    reg_addr;
  logic [15:0]   reg_wdata;
  logic          reg_wr;
  logic          reg_rd;
  logic [15:0]   reg_rdata;
  logic [4:0]    straps;
  logic          ref_clk_pin;
  logic          rec_clk_pin;
  logic          rec_dv_pin;
  logic [1:0]    rec_data_pin;
  mimc_mode_type mode;
  logic          clk_sel_50m;
  logic [3:0]    rx_delay_ns;
  logic [3:0]    tx_delay_ns;
  logic [3:0]    sgmii_thr_bits;
  logic [3:0]    ebuf_tol_bits;
  logic          rmii_crs_dv;
  logic [1:0]    rmii_rxd;
  logic          irq;
  logic [15:0]   rd_val;
  int            num_errors;
  int            comparisons;
  int            cyc;

  mimc_top #(.EB_DEPTH(8)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_rgmii(straps[4]), .strap_rmii(straps[3]), .strap_clk_sel(straps[2]),
    .strap_rx_dly(straps[1]), .strap_tx_dly(straps[0]), .ref_clk_pin(ref_clk_pin),
    .rec_clk_pin(rec_clk_pin), .rec_dv_pin(rec_dv_pin), .rec_data_pin(rec_data_pin),
    .mode(mode), .clk_sel_50m(clk_sel_50m), .rx_delay_ns(rx_delay_ns),
    .tx_delay_ns(tx_delay_ns), .sgmii_thr_bits(sgmii_thr_bits),
    .ebuf_tol_bits(ebuf_tol_bits), .rmii_crs_dv(rmii_crs_dv), .rmii_rxd(rmii_rxd),
    .irq(irq)
  );

  mimc_mac_model i_mac (
    .ref_clk(ref_clk_pin),
    .crs_dv(rmii_crs_dv),
    .rxd(rmii_rxd)
  );

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      $display("unexpected at %0t: run too long", $time);
      complete_run;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask

  // Recovered data at a chosen rate; released data line shows the inverse
  task automatic frame(input int n, input int half);
    int f0;
    int k;
    f0 = i_mac.frames;
    @(posedge core_clk);
    rec_dv_pin <= 1'b1;
    for (k = 0; k < n; k++) begin
      rec_data_pin <= 2'(k % 3 + 1);
      rec_clk_pin  <= 1'b0;
      repeat (half) @(posedge core_clk);
      rec_clk_pin <= 1'b1;
      repeat (half) @(posedge core_clk);
    end
    rec_clk_pin  <= 1'b0;
    rec_dv_pin   <= 1'b0;
    rec_data_pin <= ~rec_data_pin;
    for (k = 0; k < 2000 && i_mac.frames == f0; k++) @(posedge core_clk);
    chk(16'(i_mac.frames - f0), 16'h0001, "frame end");
  endtask

  task automatic chk_data(input int n);
    int s;
    int k;
    s = 0;
    while (s < i_mac.got.size() && i_mac.got[s] === 2'b00) s++;
    chk(16'(i_mac.got.size() >= s + n), 16'h0001, "frame length");
    for (k = 0; k < n && s + k < i_mac.got.size(); k++)
      chk(16'(i_mac.got[s + k]), 16'(k % 3 + 1), "dibit");
  endtask

  task automatic t_reset;
    rd(`MIMC_CTRL_ADDR);
    chk(rd_val, 16'h50E1, "ctrl after straps");
    chk(16'(mode), 16'(MIMC_RMII), "strapped mode");
    chk(16'(clk_sel_50m), 16'h0001, "clock select");
    chk(16'(rx_delay_ns), 16'h0002, "rx delay");
    chk(16'(tx_delay_ns), 16'h0000, "tx delay");
    chk(16'(sgmii_thr_bits), 16'h0006, "thr reset");
    chk(16'(ebuf_tol_bits), 16'h0002, "tol reset");
  endtask

  task automatic t_fields;
    logic [3:0]    thr [4] = '{4'h5, 4'h2, 4'h6, 4'hA};
    logic [3:0]    tol [4] = '{4'h5, 4'h2, 4'h3, 4'h4};
    logic [15:0]   mw  [4] = '{16'h0240, 16'h0260, 16'h0060, 16'h00C0};
    mimc_mode_type mx  [4] = '{MIMC_RGMII, MIMC_RGMII, MIMC_RMII, MIMC_MII};
    for (int i = 0; i < 4; i++) begin
      wr(`MIMC_CTRL_ADDR, 16'h0040 | 16'(i << 13) | 16'(i));
      settle;
      chk(16'(sgmii_thr_bits), 16'(thr[i]), "thr decode");
      chk(16'(ebuf_tol_bits), 16'(tol[i]), "tol decode");
      wr(`MIMC_CTRL_ADDR, mw[i]);
      settle;
      chk(16'(mode), 16'(mx[i]), "mode select");
      chk(16'(clk_sel_50m), 16'(i == 3), "clock select");
    end
    wr(`MIMC_CTRL_ADDR, 16'h1040);
    settle;
    chk({rx_delay_ns, tx_delay_ns}, 16'h0020, "rx delay only");
    wr(`MIMC_CTRL_ADDR, 16'h0840);
    settle;
    chk({rx_delay_ns, tx_delay_ns}, 16'h0002, "tx delay only");
    wr(`MIMC_CTRL_ADDR, 16'hFFFF);
    rd(`MIMC_CTRL_ADDR);
    chk(rd_val, 16'h7FFF, "all ones");
    wr(`MIMC_CTRL_ADDR, 16'h8040);
    rd(`MIMC_CTRL_ADDR);
    chk(rd_val, 16'h004C, "top bit read only");
  endtask

  task automatic t_unmapped;
    wr(8'h30, 16'hFFFF);
    rd(8'h30);
    chk(rd_val, 16'h0000, "unmapped read");
    settle;
    chk(reg_rdata, 16'h0000, "read data released");
    rd(`MIMC_CTRL_ADDR);
    chk(rd_val, 16'h004C, "ctrl untouched");
  endtask

  // Longer frames need a wider tolerance, so these runs use code 00
  task automatic t_rev(input logic rev10);
    wr(`MIMC_CTRL_ADDR, 16'h4060 | {11'h000, rev10, 4'h0});
    frame(20, 8);
    if (rev10) begin
      chk(16'(i_mac.falls), 16'h0001, "carrier held to end");
    end else begin
      chk(16'(i_mac.falls >= 2), 16'h0001, "carrier toggles at end");
    end
    chk_data(20);
  endtask

  task automatic t_overflow;
    wr(`MIMC_IRQ_MSK_ADDR, 16'h0001);
    wr(`MIMC_CTRL_ADDR, 16'h4063);
    frame(16, 2);
    chk(16'(irq), 16'h0001, "irq on overflow");
    rd(`MIMC_IRQ_STS_ADDR);
    chk(rd_val, 16'h0001, "status overflow");
    rd(`MIMC_CTRL_ADDR);
    chk(rd_val & 16'h000C, 16'h0004, "overflow flag");
    rd(`MIMC_CTRL_ADDR);
    chk(rd_val & 16'h000C, 16'h000C, "overflow cleared by read");
    wr(`MIMC_IRQ_STS_ADDR, 16'h0001);
    settle;
    chk(16'(irq), 16'h0000, "irq after clear");
    rd(`MIMC_IRQ_STS_ADDR);
    chk(rd_val, 16'h0000, "status cleared");
  endtask

  task automatic t_underflow;
    wr(`MIMC_CTRL_ADDR, 16'h4061);
    frame(10, 16);
    rd(`MIMC_IRQ_STS_ADDR);
    chk(rd_val, 16'h0002, "status underflow");
    chk(16'(irq), 16'h0000, "masked irq");
    rd(`MIMC_CTRL_ADDR);
    chk(rd_val & 16'h000C, 16'h0008, "underflow flag");
    rd(`MIMC_CTRL_ADDR);
    chk(rd_val & 16'h000C, 16'h000C, "underflow cleared by read");
    wr(`MIMC_IRQ_MSK_ADDR, 16'h0003);
    settle;
    chk(16'(irq), 16'h0001, "irq unmasked");
    wr(`MIMC_IRQ_STS_ADDR, 16'h0002);
    settle;
    chk(16'(irq), 16'h0000, "irq after clear");
  endtask

  // Second reset in mid-run with the other strap levels
  task automatic t_restrap;
    @(posedge core_clk);
    arst_n <= 1'b0;
    straps <= 5'b10001;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    settle;
    chk(16'(mode), 16'(MIMC_RGMII), "strapped rgmii");
    chk(16'(clk_sel_50m), 16'h0000, "strapped clock");
    chk({rx_delay_ns, tx_delay_ns}, 16'h0002, "strapped delays");
    rd(`MIMC_CTRL_ADDR);
    chk(rd_val, 16'h4A41, "ctrl after restrap");
  endtask

  task automatic complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    core_clk     = 1'b0;
    arst_n       = 1'b0;
    reg_addr     = 8'h00;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    straps       = 5'b01110;
    rec_clk_pin  = 1'b0;
    rec_dv_pin   = 1'b0;
    rec_data_pin = 2'b00;
    num_errors   = 0;
    comparisons  = 0;
    cyc          = 0;
    repeat (12) @(posedge core_clk);
    chk(16'(mode), 16'(MIMC_MII), "mode in reset");
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_reset;
    t_fields;
    t_unmapped;
    t_rev(1'b1);
    t_rev(1'b0);
    t_overflow;
    t_underflow;
    t_restrap;
    complete_run;
  end
endmodule

`default_nettype wire
